//--- rtl/usb_status_ext_pkg.sv
// package for the usb client status and extended register block
// assumes a 32-bit ahb-lite slave view, registers on halfword steps up to the data port, one per word from the mailbox on
// Behaviour
// - suspend request flag, write one enters suspend
// - stalled IN sets transmit stall flag
// - transmit underrun NAK sets transmit NAK flag
// - host ACK of IN sets transmit ACK
// - stalled OUT sets receive stall flag
// - other refused OUT sets receive NAK
// - accepted OUT sets receive ACK flag
// - mailbox valid from CPU write to host read
// - capture SOF frame number, high/low registers
// - index register selects extended register
// - data port reads/writes selected extended register
// - vendor code returned high byte first
// - product code returned in descriptor
// - release code returned in descriptor
// - six-bit almost-full threshold, reset sixty
// - almost-full only when count exceeds threshold
package usb_status_ext_pkg;
	// byte addresses of the registers
	localparam logic [15:0] ADDR_STATUS    = 16'h4032;
	localparam logic [15:0] ADDR_FRAME_HI  = 16'h4034;
	localparam logic [15:0] ADDR_FRAME_LO  = 16'h4036;
	localparam logic [15:0] ADDR_INDEX     = 16'h4038;
	localparam logic [15:0] ADDR_DATA      = 16'h403A;
	localparam logic [15:0] ADDR_MBOX_LO   = 16'h4040;
	localparam logic [15:0] ADDR_MBOX_HI   = 16'h4044;
	localparam logic [15:0] ADDR_IRQ_EN    = 16'h4048;
	localparam logic [15:0] ADDR_IRQ_CLR   = 16'h404C;
	localparam logic [15:0] ADDR_IRQ_STAT  = 16'h4050;
	// status bit positions
	localparam int BIT_SUSPEND  = 7;
	localparam int BIT_TX_STALL = 6;
	localparam int BIT_TX_NAK   = 5;
	localparam int BIT_TX_ACK   = 4;
	localparam int BIT_RX_STALL = 3;
	localparam int BIT_RX_NAK   = 2;
	localparam int BIT_RX_ACK   = 1;
	localparam int BIT_MBOX     = 0;
	// interrupt status layout: status flags 7..1 plus almost-full at bit 0
	localparam int IRQ_BITS     = 8;
	localparam int BIT_IRQ_AF   = 0;
	// extended indices
	localparam logic [7:0] IDX_VEND_HI = 8'h00;
	localparam logic [7:0] IDX_VEND_LO = 8'h01;
	localparam logic [7:0] IDX_PROD_HI = 8'h02;
	localparam logic [7:0] IDX_PROD_LO = 8'h03;
	localparam logic [7:0] IDX_REL_HI  = 8'h04;
	localparam logic [7:0] IDX_REL_LO  = 8'h05;
	localparam logic [7:0] IDX_AF_LVL  = 8'h06;
	localparam int EXT_REGS = 7;
	// reset values; identity defaults are arbitrary
	localparam logic [7:0] RST_VEND_HI = 8'h5A;
	localparam logic [7:0] RST_VEND_LO = 8'h11;
	localparam logic [7:0] RST_PROD_HI = 8'h33;
	localparam logic [7:0] RST_PROD_LO = 8'h44;
	localparam logic [7:0] RST_REL_HI  = 8'h02;
	localparam logic [7:0] RST_REL_LO  = 8'h00;
	localparam logic [5:0] RST_AF_LVL  = 6'h3C;
	localparam int FRAME_W = 11;
	localparam int LEVEL_W = 7;
	localparam int DESC_BYTES = 6;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : usb_status_ext_pkg

//--- rtl/usb_client_status_ext_regs.sv
// usb client handshake status, frame number capture and extended register window
// assumes the usb engine reports handshakes as one-cycle pulses on mclk
`timescale 1ns/1ps
module usb_client_status_ext_regs (
	// clock and reset
	input  wire logic                                  mclk,
	input  wire logic                                  rst,
	// ahb-lite slave
	input  wire logic                                  hsel,
	input  wire logic [31:0]                           haddr,
	input  wire logic [1:0]                            htrans,
	input  wire logic                                  hwrite,
	input  wire logic [2:0]                            hsize,
	input  wire logic [31:0]                           hwdata,
	input  wire logic                                  hready,
	output logic      [31:0]                           hrdata,
	output logic                                       hreadyout,
	output logic                                       hresp,
	// usb engine events
	input  wire logic                                  suspend_req,
	input  wire logic                                  in_token,
	input  wire logic                                  in_ack,
	input  wire logic                                  tx_underrun,
	input  wire logic                                  out_packet,
	input  wire logic                                  out_accept,
	input  wire logic                                  tx_stall_ctl,
	input  wire logic                                  rx_stall_ctl,
	input  wire logic                                  mbox_host_read,
	input  wire logic                                  sof_valid,
	input  wire logic [usb_status_ext_pkg::FRAME_W-1:0] sof_frame,
	input  wire logic [usb_status_ext_pkg::LEVEL_W-1:0] rx_level,
	// descriptor byte fetch (0..5: vendor, product, release, high first)
	input  wire logic [2:0]                            desc_sel,
	output logic      [7:0]                            desc_byte,
	// handshake answers and status
	output logic                                       ans_stall,
	output logic                                       ans_nak,
	output logic                                       ans_ack,
	output logic                                       enter_suspend,
	output logic                                       rx_almost_full,
	output logic      [63:0]                           mbox_data,
	output logic                                       irq
);
	import usb_status_ext_pkg::*;

	typedef struct packed {
		logic                   ph_wr;
		logic                   ph_rd;
		logic [15:0]            ph_addr;
		logic [31:0]            rdata;
		logic [7:0]             status;
		logic [FRAME_W-1:0]     frame;
		logic [7:0]             index;
		logic [7:0]             vend_hi;
		logic [7:0]             vend_lo;
		logic [7:0]             prod_hi;
		logic [7:0]             prod_lo;
		logic [7:0]             rel_hi;
		logic [7:0]             rel_lo;
		logic [5:0]             af_lvl;
		logic                   af;
		logic [IRQ_BITS-1:0]    irq_stat;
		logic [IRQ_BITS-1:0]    irq_en;
		logic                   irq;
		logic [63:0]            mbox;
		logic                   suspend;
		logic                   stall;
		logic                   nak;
		logic                   ack;
		logic [7:0]             desc;
		logic                   rdy;
		logic                   resp;
	} state_t;

	state_t st_ff;
	state_t nxt_st;
	logic   [7:0] ext_rd;
	logic   [7:0] clr;
	logic   [7:0] set;
	logic         af_rise;
	logic [IRQ_BITS-1:0] irq_set;

	// extended register read mux, zero for unimplemented indices
	always_comb begin
		case (st_ff.index)
			IDX_VEND_HI: ext_rd = st_ff.vend_hi;
			IDX_VEND_LO: ext_rd = st_ff.vend_lo;
			IDX_PROD_HI: ext_rd = st_ff.prod_hi;
			IDX_PROD_LO: ext_rd = st_ff.prod_lo;
			IDX_REL_HI:  ext_rd = st_ff.rel_hi;
			IDX_REL_LO:  ext_rd = st_ff.rel_lo;
			IDX_AF_LVL:  ext_rd = {2'h0, st_ff.af_lvl};
			default:     ext_rd = 8'h00;
		endcase
	end

	// handshake events; stall takes priority over nak, set wins over clear
	always_comb begin
		set = 8'h00;
		set[BIT_SUSPEND]  = suspend_req;
		set[BIT_TX_STALL] = in_token & tx_stall_ctl;
		set[BIT_TX_NAK]   = in_token & ~tx_stall_ctl & tx_underrun;
		set[BIT_TX_ACK]   = in_ack;
		set[BIT_RX_STALL] = out_packet & rx_stall_ctl;
		set[BIT_RX_NAK]   = out_packet & ~rx_stall_ctl & ~out_accept;
		set[BIT_RX_ACK]   = out_packet & ~rx_stall_ctl & out_accept;
		clr = (st_ff.ph_wr && st_ff.ph_addr == ADDR_STATUS) ? hwdata[7:0] : 8'h00;
		clr[BIT_MBOX] = 1'b0; // mailbox flag is cleared only by the host read
		// count strictly above threshold, so a count equal to the threshold never fires
		af_rise = ({1'b0, st_ff.af_lvl} < rx_level) & ~st_ff.af;
		irq_set = {set[7:1], af_rise};
	end

	// next-state logic: bus slave, flags, extended window
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ph_wr = hsel & hready & htrans[1] & hwrite;
		nxt_st.ph_rd = hsel & hready & htrans[1] & ~hwrite;
		if (hsel && hready && htrans[1]) begin
			nxt_st.ph_addr = haddr[15:0];
		end
		// flags: set wins over clear
		nxt_st.status[7:1] = (st_ff.status[7:1] & ~clr[7:1]) | set[7:1];
		nxt_st.suspend = clr[BIT_SUSPEND] & st_ff.status[BIT_SUSPEND];
		// mailbox: host read clears, cpu write of high word sets (set wins)
		if (mbox_host_read) begin
			nxt_st.status[BIT_MBOX] = 1'b0;
		end
		if (st_ff.ph_wr) begin
			case (st_ff.ph_addr)
				ADDR_INDEX: nxt_st.index = hwdata[7:0];
				ADDR_MBOX_LO: nxt_st.mbox[31:0] = hwdata;
				ADDR_MBOX_HI: begin
					nxt_st.mbox[63:32] = hwdata;
					nxt_st.status[BIT_MBOX] = 1'b1;
				end
				ADDR_IRQ_EN: nxt_st.irq_en = hwdata[IRQ_BITS-1:0];
				ADDR_DATA: begin
					case (st_ff.index)
						IDX_VEND_HI: nxt_st.vend_hi = hwdata[7:0];
						IDX_VEND_LO: nxt_st.vend_lo = hwdata[7:0];
						IDX_PROD_HI: nxt_st.prod_hi = hwdata[7:0];
						IDX_PROD_LO: nxt_st.prod_lo = hwdata[7:0];
						IDX_REL_HI:  nxt_st.rel_hi = hwdata[7:0];
						IDX_REL_LO:  nxt_st.rel_lo = hwdata[7:0];
						IDX_AF_LVL:  nxt_st.af_lvl = hwdata[5:0];
						default:     nxt_st.index = st_ff.index;
					endcase
				end
				default: nxt_st.index = st_ff.index;
			endcase
		end
		// frame number of the latest start of frame
		if (sof_valid) begin
			nxt_st.frame = sof_frame;
		end
		// almost-full level status
		nxt_st.af = {1'b0, st_ff.af_lvl} < rx_level;
		// interrupt status: write-one clear, set wins
		if (st_ff.ph_wr && st_ff.ph_addr == ADDR_IRQ_CLR) begin
			nxt_st.irq_stat = (st_ff.irq_stat & ~hwdata[IRQ_BITS-1:0]) | irq_set;
		end else begin
			nxt_st.irq_stat = st_ff.irq_stat | irq_set;
		end
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_en);
		// handshake answers, registered one cycle after the token
		nxt_st.stall = set[BIT_TX_STALL] | set[BIT_RX_STALL];
		nxt_st.nak = set[BIT_TX_NAK] | set[BIT_RX_NAK];
		nxt_st.ack = set[BIT_RX_ACK];
		// descriptor byte stream, high byte first
		case (desc_sel)
			3'h0: nxt_st.desc = st_ff.vend_hi;
			3'h1: nxt_st.desc = st_ff.vend_lo;
			3'h2: nxt_st.desc = st_ff.prod_hi;
			3'h3: nxt_st.desc = st_ff.prod_lo;
			3'h4: nxt_st.desc = st_ff.rel_hi;
			3'h5: nxt_st.desc = st_ff.rel_lo;
			default: nxt_st.desc = 8'h00;
		endcase
		// read data prepared in the address phase for a zero-wait answer
		nxt_st.rdata = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			case (haddr[15:0])
				ADDR_STATUS:   nxt_st.rdata = {24'h0, st_ff.status};
				ADDR_FRAME_HI: nxt_st.rdata = {29'h0, st_ff.frame[10:8]};
				ADDR_FRAME_LO: nxt_st.rdata = {24'h0, st_ff.frame[7:0]};
				ADDR_INDEX:    nxt_st.rdata = {24'h0, st_ff.index};
				ADDR_DATA:     nxt_st.rdata = {24'h0, ext_rd};
				ADDR_MBOX_LO:  nxt_st.rdata = st_ff.mbox[31:0];
				ADDR_MBOX_HI:  nxt_st.rdata = st_ff.mbox[63:32];
				ADDR_IRQ_EN:   nxt_st.rdata = {24'h0, st_ff.irq_en};
				ADDR_IRQ_STAT: nxt_st.rdata = {24'h0, st_ff.irq_stat};
				default:       nxt_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	// single state register; identity codes load their defaults
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_ff         <= '0;
			st_ff.vend_hi <= RST_VEND_HI;
			st_ff.vend_lo <= RST_VEND_LO;
			st_ff.prod_hi <= RST_PROD_HI;
			st_ff.prod_lo <= RST_PROD_LO;
			st_ff.rel_hi  <= RST_REL_HI;
			st_ff.rel_lo  <= RST_REL_LO;
			st_ff.af_lvl  <= RST_AF_LVL;
			// zero-wait slave: ready from reset on, never stretched
			st_ff.rdy     <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// every output is a plain view of a state flop
	assign hrdata         = st_ff.rdata;
	assign hreadyout      = st_ff.rdy;
	assign hresp          = st_ff.resp;
	assign desc_byte      = st_ff.desc;
	assign ans_stall      = st_ff.stall;
	assign ans_nak        = st_ff.nak;
	assign ans_ack        = st_ff.ack;
	assign enter_suspend  = st_ff.suspend;
	assign rx_almost_full = st_ff.af;
	assign mbox_data      = st_ff.mbox;
	assign irq            = st_ff.irq;

	// protocol checks; each watches what this block drives after an event
	// a stalled IN sets the tx stall flag and answers STALL
	property p_tx_stall;
		@(posedge mclk) disable iff (rst)
			(in_token && tx_stall_ctl) |=> st_ff.status[BIT_TX_STALL] && ans_stall;
	endproperty
	a_tx_stall: assert property (p_tx_stall) else $error("tx stall flag not set");
	// stall outranks nak, so a stalled IN on its own never answers NAK
	property p_tx_no_nak;
		@(posedge mclk) disable iff (rst)
			(in_token && tx_stall_ctl && !out_packet) |=> !ans_nak;
	endproperty
	a_tx_no_nak: assert property (p_tx_no_nak) else $error("stalled IN got NAK");
	// an underrun on an unstalled IN sets the tx nak flag and answers NAK
	property p_tx_nak;
		@(posedge mclk) disable iff (rst)
			(in_token && !tx_stall_ctl && tx_underrun) |=> st_ff.status[BIT_TX_NAK] && ans_nak;
	endproperty
	a_tx_nak: assert property (p_tx_nak) else $error("tx nak flag not set");
	// the host's ACK of an IN sets the tx ack flag
	property p_tx_ack;
		@(posedge mclk) disable iff (rst)
			in_ack |=> st_ff.status[BIT_TX_ACK];
	endproperty
	a_tx_ack: assert property (p_tx_ack) else $error("tx ack flag not set");
	// a write of one clears it, unless a new ACK lands in that cycle
	property p_ack_clr;
		@(posedge mclk) disable iff (rst)
			(st_ff.ph_wr && st_ff.ph_addr == ADDR_STATUS && hwdata[BIT_TX_ACK] && !in_ack)
			|=> !st_ff.status[BIT_TX_ACK];
	endproperty
	a_ack_clr: assert property (p_ack_clr) else $error("tx ack flag not cleared");

	// a stalled OUT sets the rx stall flag and answers STALL, never ACK
	property p_rx_stall;
		@(posedge mclk) disable iff (rst)
			(out_packet && rx_stall_ctl)
			|=> st_ff.status[BIT_RX_STALL] && ans_stall && !ans_ack;
	endproperty
	a_rx_stall: assert property (p_rx_stall) else $error("rx stall flag not set");
	// an OUT refused for another reason sets the rx nak flag and answers NAK
	property p_rx_nak;
		@(posedge mclk) disable iff (rst)
			(out_packet && !rx_stall_ctl && !out_accept) |=> st_ff.status[BIT_RX_NAK] && ans_nak;
	endproperty
	a_rx_nak: assert property (p_rx_nak) else $error("rx nak flag not set");
	// an accepted OUT sets the rx ack flag and answers ACK
	property p_rx_ack;
		@(posedge mclk) disable iff (rst)
			(out_packet && !rx_stall_ctl && out_accept) |=> st_ff.status[BIT_RX_ACK] && ans_ack;
	endproperty
	a_rx_ack: assert property (p_rx_ack) else $error("rx ack flag not set");

	// writing one to a pending suspend flag enters suspend and clears it
	property p_suspend;
		@(posedge mclk) disable iff (rst)
			(st_ff.ph_wr && st_ff.ph_addr == ADDR_STATUS && hwdata[BIT_SUSPEND]
			&& st_ff.status[BIT_SUSPEND] && !suspend_req)
			|=> enter_suspend && !st_ff.status[BIT_SUSPEND];
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspend entry missed");

	// the mailbox flag holds until the host read
	property p_mbox;
		@(posedge mclk) disable iff (rst)
			(st_ff.status[BIT_MBOX] && !mbox_host_read) |=> st_ff.status[BIT_MBOX];
	endproperty
	a_mbox: assert property (p_mbox) else $error("mailbox flag dropped early");
	// the cpu's write of the high mailbox word raises the flag
	property p_mbox_set;
		@(posedge mclk) disable iff (rst)
			(st_ff.ph_wr && st_ff.ph_addr == ADDR_MBOX_HI) |=> st_ff.status[BIT_MBOX];
	endproperty
	a_mbox_set: assert property (p_mbox_set) else $error("mailbox flag not set");
	// a host read drops the flag unless the cpu refills it in that cycle
	property p_mbox_clr;
		@(posedge mclk) disable iff (rst)
			(mbox_host_read && !(st_ff.ph_wr && st_ff.ph_addr == ADDR_MBOX_HI))
			|=> !st_ff.status[BIT_MBOX];
	endproperty
	a_mbox_clr: assert property (p_mbox_clr) else $error("mailbox flag kept");

	// the frame number is captured with its strobe
	property p_frame;
		@(posedge mclk) disable iff (rst)
			sof_valid |=> st_ff.frame == $past(sof_frame);
	endproperty
	a_frame: assert property (p_frame) else $error("frame not captured");
	// and held between strobes, whatever the frame bus shows
	property p_frame_hold;
		@(posedge mclk) disable iff (rst)
			!sof_valid |=> $stable(st_ff.frame);
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("frame changed");

	// the index register takes the written byte
	property p_index_wr;
		@(posedge mclk) disable iff (rst)
			(st_ff.ph_wr && st_ff.ph_addr == ADDR_INDEX)
			|=> st_ff.index == $past(hwdata[7:0]);
	endproperty
	a_index_wr: assert property (p_index_wr) else $error("index not written");
	// a data port read at an unimplemented index answers zero
	property p_ext_zero;
		@(posedge mclk) disable iff (rst)
			(hsel && hready && htrans[1] && !hwrite && haddr[15:0] == ADDR_DATA
			&& st_ff.index > IDX_AF_LVL) |=> hrdata == 32'h0000_0000;
	endproperty
	a_ext_zero: assert property (p_ext_zero) else $error("ext read not zero");
	// a data port write there leaves every extended register alone
	property p_ext_ignore;
		@(posedge mclk) disable iff (rst)
			(st_ff.ph_wr && st_ff.ph_addr == ADDR_DATA && st_ff.index > IDX_AF_LVL)
			|=> $stable({st_ff.vend_hi, st_ff.vend_lo, st_ff.prod_hi, st_ff.prod_lo,
			st_ff.rel_hi, st_ff.rel_lo, st_ff.af_lvl});
	endproperty
	a_ext_ignore: assert property (p_ext_ignore) else $error("stray ext write");

	// descriptor stream opens with the vendor high byte
	property p_desc_vend;
		@(posedge mclk) disable iff (rst)
			(!rst && desc_sel == 3'h0) |=> desc_byte == $past(st_ff.vend_hi);
	endproperty
	a_desc_vend: assert property (p_desc_vend) else $error("vendor byte wrong");
	// product low byte comes from its own extended register
	property p_desc_prod;
		@(posedge mclk) disable iff (rst)
			(!rst && desc_sel == 3'h3) |=> desc_byte == $past(st_ff.prod_lo);
	endproperty
	a_desc_prod: assert property (p_desc_prod) else $error("product byte wrong");
	// release high byte likewise
	property p_desc_rel;
		@(posedge mclk) disable iff (rst)
			(!rst && desc_sel == 3'h4) |=> desc_byte == $past(st_ff.rel_hi);
	endproperty
	a_desc_rel: assert property (p_desc_rel) else $error("release byte wrong");

	// almost-full only once the count has passed the threshold
	property p_af;
		@(posedge mclk) disable iff (rst)
			rx_almost_full |-> ($past(rx_level) > {1'b0, $past(st_ff.af_lvl)});
	endproperty
	a_af: assert property (p_af) else $error("almost full without excess");
	// and always once it has
	property p_af_level;
		@(posedge mclk) disable iff (rst)
			({1'b0, st_ff.af_lvl} < rx_level) |=> rx_almost_full;
	endproperty
	a_af_level: assert property (p_af_level) else $error("almost full missed");
endmodule : usb_client_status_ext_regs

//--- tb/usb_engine_model.sv
// far-side usb engine model: handshakes, sof strobe and frame number, mailbox read, fifo level
// assumes its tasks are called by the bench from the mclk domain
`timescale 1ns/1ps
module usb_engine_model (
	// clock
	input  wire logic                                   mclk,
	// handshake events and levels
	output logic                                        suspend_req,
	output logic                                        in_token,
	output logic                                        in_ack,
	output logic                                        tx_underrun,
	output logic                                        out_packet,
	output logic                                        out_accept,
	output logic                                        tx_stall_ctl,
	output logic                                        rx_stall_ctl,
	output logic                                        mbox_host_read,
	// frame and fifo
	output logic                                        sof_valid,
	output logic [usb_status_ext_pkg::FRAME_W-1:0]      sof_frame,
	output logic [usb_status_ext_pkg::LEVEL_W-1:0]      rx_level
);
	import usb_status_ext_pkg::*;

	// everything quiet at time zero
	initial begin
		{suspend_req, in_token, in_ack, tx_underrun, out_packet, out_accept} = '0;
		{tx_stall_ctl, rx_stall_ctl, mbox_host_read, sof_valid, sof_frame, rx_level} = '0;
	end

	// one transaction: 0 in stalled, 1 in underrun, 2 in acked, 3 out stalled,
	// 4 out refused, 5 out accepted, 6 suspend request, 7 mailbox read by host
	task automatic pulse(input int k);
		@(posedge mclk);
		tx_stall_ctl <= (k == 0);
		rx_stall_ctl <= (k == 3);
		in_token <= (k < 2);
		tx_underrun <= (k == 1);
		in_ack <= (k == 2);
		out_packet <= (k >= 3 && k <= 5);
		out_accept <= (k == 5);
		suspend_req <= (k == 6);
		mbox_host_read <= (k == 7);
		@(posedge mclk);
		{in_token, tx_underrun, in_ack, out_packet, out_accept, suspend_req} <= '0;
		{tx_stall_ctl, rx_stall_ctl, mbox_host_read} <= '0;
	endtask : pulse

	// frame number only valid with its strobe; afterwards the bus shows junk
	task automatic sof(input logic [FRAME_W-1:0] f);
		@(posedge mclk);
		sof_valid <= 1'b1;
		sof_frame <= f;
		@(posedge mclk);
		sof_valid <= 1'b0;
		sof_frame <= ~f;
	endtask : sof

	// fifo count never exceeds the depth of sixty-four
	task automatic level(input logic [LEVEL_W-1:0] l);
		@(posedge mclk);
		rx_level <= (l > 7'd64) ? 7'd64 : l;
	endtask : level
endmodule : usb_engine_model

//--- tb/usb_client_status_ext_regs_bench.sv
// self-checking bench for the usb client status and extended register block
// assumes a zero-wait ahb-lite slave and the engine model on the same clock
`timescale 1ns/1ps
module usb_client_status_ext_regs_bench;
	import usb_status_ext_pkg::*;
	logic                  mclk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0]           haddr, hwdata, hrdata;
	logic [1:0]            htrans;
	logic [2:0]            hsize, desc_sel;
	logic [7:0]            desc_byte;
	logic [63:0]           mbox_data;
	logic                  suspend_req, in_token, in_ack, tx_underrun, out_packet;
	logic                  out_accept, tx_stall_ctl, rx_stall_ctl, mbox_host_read;
	logic                  sof_valid, ans_stall, ans_nak, ans_ack;
	logic                  enter_suspend, rx_almost_full, irq;
	logic [FRAME_W-1:0]    sof_frame;
	logic [LEVEL_W-1:0]    rx_level;
	int                    errors, comparisons, susp_cnt;

	assign hready = hreadyout;

	usb_client_status_ext_regs i_dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .suspend_req, .in_token, .in_ack,
		.tx_underrun, .out_packet, .out_accept, .tx_stall_ctl, .rx_stall_ctl,
		.mbox_host_read, .sof_valid, .sof_frame, .rx_level, .desc_sel, .desc_byte,
		.ans_stall, .ans_nak, .ans_ack, .enter_suspend, .rx_almost_full, .mbox_data, .irq);

	usb_engine_model i_host (.mclk, .suspend_req, .in_token, .in_ack, .tx_underrun,
		.out_packet, .out_accept, .tx_stall_ctl, .rx_stall_ctl, .mbox_host_read,
		.sof_valid, .sof_frame, .rx_level);

	// 25 MHz clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// suspend entry pulses are counted, their exact cycle is the design's choice
	always @(posedge mclk) if (enter_suspend === 1'b1) susp_cnt++;

	task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", s, e, g);
		end
	endtask : chk

	// one single word transfer; waits on hready in both phases
	task automatic ahb(input logic w, input logic [1:0] t, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= t;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		q = hrdata;
		chk("hresp", 64'h0, hresp);
	endtask : ahb

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, HTRANS_NONSEQ, a, d, q);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] e, input string s);
		logic [31:0] q;
		ahb(1'b0, HTRANS_NONSEQ, a, 32'h0, q);
		chk(s, e, q);
	endtask : rd

	task automatic settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask : settle

	task automatic t_ext;
		logic [7:0] dflt [8] = '{RST_VEND_HI, RST_VEND_LO, RST_PROD_HI, RST_PROD_LO,
			RST_REL_HI, RST_REL_LO, {2'b00, RST_AF_LVL}, 8'h00};
		rd(ADDR_INDEX, 32'h0, "index reset");
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_INDEX, i);
			rd(ADDR_DATA, {24'h0, dflt[i]}, "ext default");
			desc_sel <= 3'(i);
			settle();
			chk("desc byte", (i < 6) ? dflt[i] : 8'h00, desc_byte);
		end
		wr(ADDR_INDEX, IDX_PROD_LO);
		wr(ADDR_DATA, 32'h9C);
		rd(ADDR_DATA, 32'h9C, "ext write");
		desc_sel <= 3'd3;
		settle();
		chk("desc product", 8'h9C, desc_byte);
		wr(ADDR_INDEX, 32'h80);
		wr(ADDR_DATA, 32'h55);
		rd(ADDR_DATA, 32'h0, "ext unimplemented");
		rd(ADDR_INDEX, 32'h80, "index readback");
		$display("test ext done");
	endtask : t_ext

	// idle transfers with hsel high are not taken; upper address bits not decoded
	task automatic t_idle;
		logic [31:0] q;
		wr(ADDR_INDEX, 32'h05);
		ahb(1'b1, 2'h0, ADDR_INDEX, 32'h03, q);
		ahb(1'b0, 2'h0, ADDR_INDEX, 32'h0, q);
		chk("idle read", 32'h0, q);
		rd(ADDR_INDEX, 32'h05, "idle write ignored");
		rd({16'hFFFF, ADDR_INDEX}, 32'h05, "upper address");
		$display("test idle done");
	endtask : t_idle

	task automatic t_events;
		wr(ADDR_IRQ_EN, 32'hFE);
		for (int k = 0; k < 6; k++) begin
			i_host.pulse(k);
			#1;
			// the host's own ACK of an IN needs no answer from the device
			chk("answer", (k == 2) ? 3'b000 : 3'b100 >> (k % 3), {ans_stall, ans_nak, ans_ack});
			chk("irq set", 1'b1, irq);
			rd(ADDR_STATUS, 32'h1 << (6 - k), "flag");
			rd(ADDR_IRQ_STAT, 32'h1 << (6 - k), "irq status");
			wr(ADDR_STATUS, 32'h1 << (6 - k));
			wr(ADDR_IRQ_CLR, 32'hFF);
			settle();
			chk("irq clear", 1'b0, irq);
			rd(ADDR_STATUS, 32'h0, "flag cleared");
		end
		$display("test events done");
	endtask : t_events

	task automatic t_suspend;
		i_host.pulse(6);
		rd(ADDR_STATUS, 32'h80, "suspend flag");
		wr(ADDR_STATUS, 32'h80);
		settle();
		chk("suspend pulses", 1, susp_cnt);
		rd(ADDR_STATUS, 32'h0, "suspend cleared");
		wr(ADDR_IRQ_CLR, 32'hFF);
		$display("test suspend done");
	endtask : t_suspend

	task automatic t_mbox;
		wr(ADDR_MBOX_LO, 32'h44332211);
		rd(ADDR_STATUS, 32'h0, "mailbox half");
		wr(ADDR_MBOX_HI, 32'h88776655);
		#1;
		chk("mailbox data", 64'h8877665544332211, mbox_data);
		wr(ADDR_STATUS, 32'h1);
		rd(ADDR_STATUS, 32'h1, "mailbox held");
		i_host.pulse(7); // next mailbox write only after the host read
		rd(ADDR_STATUS, 32'h0, "mailbox read");
		$display("test mailbox done");
	endtask : t_mbox

	task automatic t_frame;
		i_host.sof(11'h6A5);
		wr(ADDR_FRAME_LO, 32'hFF);
		rd(ADDR_FRAME_HI, 32'h6, "frame high");
		rd(ADDR_FRAME_LO, 32'hA5, "frame low");
		wr(16'h4060, 32'hFFFFFFFF);
		rd(16'h4060, 32'h0, "unmapped");
		rd(ADDR_IRQ_CLR, 32'h0, "clear reads zero");
		$display("test frame done");
	endtask : t_frame

	task automatic t_level;
		wr(ADDR_IRQ_EN, 32'h0);
		i_host.level(7'd60);
		settle();
		chk("af at threshold", 1'b0, rx_almost_full);
		i_host.level(7'd61);
		settle();
		chk("af above", 1'b1, rx_almost_full);
		chk("irq masked", 1'b0, irq);
		rd(ADDR_IRQ_STAT, 32'h1, "af event");
		wr(ADDR_IRQ_EN, 32'h1);
		settle();
		chk("irq enabled", 1'b1, irq);
		wr(ADDR_IRQ_CLR, 32'h1);
		settle();
		chk("irq cleared", 1'b0, irq);
		wr(ADDR_INDEX, IDX_AF_LVL);
		wr(ADDR_DATA, 32'h0A); // kept below the depth of sixty-four
		i_host.level(7'd10);
		settle();
		chk("af new threshold", 1'b0, rx_almost_full);
		i_host.level(7'd11);
		settle();
		chk("af above new", 1'b1, rx_almost_full);
		$display("test level done");
	endtask : t_level

	task automatic summarize;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	// watchdog: the whole run needs well under 5000 cycles
	initial begin
		#(40 * 20000);
		errors++;
		summarize();
	end

	initial begin
		{rst, hsel, hwrite} = 3'b100;
		{haddr, hwdata, htrans, hsize, desc_sel} = '0;
		{errors, comparisons, susp_cnt} = '0;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		t_ext();
		t_idle();
		t_events();
		t_suspend();
		t_mbox();
		t_frame();
		t_level();
		summarize();
	end
endmodule : usb_client_status_ext_regs_bench
